// file: verilog/ars_top.sv
// regular conversion sequence bank with apb slave and rank-order sequencer
// assumes an analog core that takes one channel per request and answers with a done pulse

module ars_top (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`ARS_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CONV_REQ,
  output ars_pkg::ars_chan_t CONV_CHANNEL,
  input wire logic CONV_DONE,
  input wire ars_pkg::ars_result_t CONV_RESULT,
  output logic CONV_EOC,
  output logic SEQ_EOS,
  output logic SEQ_BUSY
);
  import ars_pkg::*;

  ars_rank_if rif ();

  ars_rank_store u_store (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .rif(rif)
  );

  ars_len_t len_reg;
  ars_result_t data_reg;
  logic start_reg;
  ars_state_e state_reg;
  ars_state_e state_next;
  logic [3:0] rank_reg;
  logic req_reg;
  ars_chan_t chan_reg;
  logic eoc_reg;
  logic eos_reg;
  logic [31:0] prdata_reg;
  logic [31:0] seq_img [`ARS_NUM_SEQ_REGS];

  // bus decode
  wire setup = PSEL && !PENABLE;
  wire access_wr = PSEL && PENABLE && PWRITE;
  wire full_word = (PSTRB == 4'hF);
  wire hit_ctrl = (PADDR == `ARS_CTRL_OFF);
  wire hit_stat = (PADDR == `ARS_STAT_OFF);
  wire hit_seq1 = (PADDR == `ARS_SEQ1_OFF);
  wire hit_seq2 = (PADDR == `ARS_SEQ2_OFF);
  wire hit_seq3 = (PADDR == `ARS_SEQ3_OFF);
  wire hit_seq4 = (PADDR == `ARS_SEQ4_OFF);
  wire hit_data = (PADDR == `ARS_DATA_OFF);
  wire hit_any = hit_ctrl || hit_stat || hit_seq1 || hit_seq2 || hit_seq3 || hit_seq4 || hit_data;
  wire wr_ok = access_wr && full_word && hit_any;
  wire [3:0] seq_wr = {wr_ok && hit_seq4, wr_ok && hit_seq3, wr_ok && hit_seq2, wr_ok && hit_seq1};
  wire len_wr = seq_wr[0];
  wire start_wr = wr_ok && hit_ctrl && PWDATA[`ARS_CTRL_START_BIT] && !start_reg;
  wire last_rank = (rank_reg == len_reg);
  wire seq_done = (state_reg == ARS_WAIT) && CONV_DONE && last_rank;

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (!hit_any || (PWRITE && !full_word));

  // rank r sits at slot r+1 counting the length field as slot 0
  for (genvar r = 0; r < `ARS_NUM_RANKS; r++) begin : g_map
    localparam int SLOT = r + 1;
    assign rif.wr_en[r] = seq_wr[SLOT / `ARS_SLOTS_PER_REG];
    assign rif.wr_chan[r] = PWDATA[`ARS_SLOT_STEP * (SLOT % `ARS_SLOTS_PER_REG) +: `ARS_CHAN_W];
  end

  // readback image, reserved bits read as zero
  always_comb begin
    for (int k = 0; k < `ARS_NUM_SEQ_REGS; k++) begin
      seq_img[k] = `ARS_SEQ_RESET;
    end
    seq_img[0][`ARS_LEN_LSB +: `ARS_LEN_W] = len_reg;
    for (int r = 0; r < `ARS_NUM_RANKS; r++) begin
      seq_img[(r + 1) / `ARS_SLOTS_PER_REG][`ARS_SLOT_STEP * ((r + 1) % `ARS_SLOTS_PER_REG) +: `ARS_CHAN_W] =
        rif.ranks[r];
    end
  end

  wire [31:0] ctrl_word = {31'h00000000, start_reg};
  wire [31:0] stat_word = {24'h000000, rank_reg, 3'h0, SEQ_BUSY};
  wire [31:0] data_word = {16'h0000, data_reg};
  wire [31:0] rd_word = hit_ctrl ? ctrl_word :
                        hit_stat ? stat_word :
                        hit_seq1 ? seq_img[0] :
                        hit_seq2 ? seq_img[1] :
                        hit_seq3 ? seq_img[2] :
                        hit_seq4 ? seq_img[3] :
                        hit_data ? data_word : 32'h00000000;

  // read data is captured in the setup cycle so it stands through the access cycle
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      prdata_reg <= 32'h00000000;
    end else if (setup && !PWRITE) begin
      prdata_reg <= rd_word;
    end
  end
  assign PRDATA = prdata_reg;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      len_reg <= `ARS_LEN_RESET;
    end else if (len_wr) begin
      len_reg <= PWDATA[`ARS_LEN_LSB +: `ARS_LEN_W];
    end
  end

  // start flag: set by software, cleared by the sequencer once the last rank completes
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      start_reg <= 1'b0;
    end else if (start_wr) begin
      start_reg <= 1'b1;
    end else if (seq_done) begin
      start_reg <= 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ARS_IDLE: begin
        if (start_reg) begin
          state_next = ARS_FETCH;
        end
      end
      ARS_FETCH: begin
        state_next = ARS_ISSUE;
      end
      ARS_ISSUE: begin
        state_next = ARS_WAIT;
      end
      ARS_WAIT: begin
        if (CONV_DONE) begin
          state_next = last_rank ? ARS_IDLE : ARS_FETCH;
        end
      end
      default: begin
        state_next = ARS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ARS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // rank counter walks upward from rank zero and stops at the programmed length
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rank_reg <= 4'h0;
    end else if (state_reg == ARS_IDLE) begin
      rank_reg <= 4'h0;
    end else if (state_reg == ARS_WAIT && CONV_DONE && !last_rank) begin
      rank_reg <= rank_reg + 4'h1;
    end
  end
  assign rif.rd_idx = rank_reg;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      req_reg <= 1'b0;
      chan_reg <= `ARS_CHAN_RESET;
    end else if (state_reg == ARS_ISSUE) begin
      req_reg <= 1'b1;
      chan_reg <= rif.rd_chan;
    end else if (state_reg == ARS_WAIT && CONV_DONE) begin
      req_reg <= 1'b0;
    end
  end

  // result register is loaded only by the analog core, bus writes do not reach it
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      data_reg <= `ARS_DATA_RESET;
    end else if (state_reg == ARS_WAIT && CONV_DONE) begin
      data_reg <= CONV_RESULT;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      eoc_reg <= 1'b0;
      eos_reg <= 1'b0;
    end else begin
      eoc_reg <= (state_reg == ARS_WAIT) && CONV_DONE;
      eos_reg <= seq_done;
    end
  end

  assign CONV_REQ = req_reg;
  assign CONV_CHANNEL = chan_reg;
  assign CONV_EOC = eoc_reg;
  assign SEQ_EOS = eos_reg;
  assign SEQ_BUSY = start_reg;
endmodule

// file: include/ars_defines.svh
// constants of the regular sequence register bank: offsets, field positions, resets
// assumes 32-bit apb data with a 12-bit byte address
`ifndef ARS_DEFINES_SVH
`define ARS_DEFINES_SVH

`define ARS_ADDR_W 12
`define ARS_CTRL_OFF 12'h000
`define ARS_STAT_OFF 12'h004
`define ARS_SEQ1_OFF 12'h030
`define ARS_SEQ2_OFF 12'h034
`define ARS_SEQ3_OFF 12'h038
`define ARS_SEQ4_OFF 12'h03C
`define ARS_DATA_OFF 12'h040

`define ARS_NUM_RANKS 16
`define ARS_NUM_SEQ_REGS 4
`define ARS_CHAN_W 5
`define ARS_LEN_W 4
`define ARS_LEN_LSB 0
`define ARS_SLOT_STEP 6
`define ARS_SLOTS_PER_REG 5
`define ARS_RESULT_W 16

`define ARS_CTRL_START_BIT 0
`define ARS_STAT_BUSY_BIT 0
`define ARS_STAT_RANK_LSB 4

`define ARS_SEQ_RESET 32'h00000000
`define ARS_DATA_RESET 16'h0000
`define ARS_LEN_RESET 4'h0
`define ARS_CHAN_RESET 5'h00

`endif

// file: include/ars_pkg.sv
// types shared by the regular sequence bank and its rank store
// assumes ars_defines.svh on the include path
`include "ars_defines.svh"

package ars_pkg;
  typedef logic [`ARS_CHAN_W-1:0] ars_chan_t;
  typedef logic [`ARS_LEN_W-1:0] ars_len_t;
  typedef logic [`ARS_RESULT_W-1:0] ars_result_t;
  typedef enum logic [1:0] {ARS_IDLE, ARS_FETCH, ARS_ISSUE, ARS_WAIT} ars_state_e;
endpackage

// file: include/ars_rank_if.sv
// carrier between the bank's control logic and its rank store
// assumes both ends run on one clock
`include "ars_defines.svh"
interface ars_rank_if;
  import ars_pkg::*;
  wire [`ARS_NUM_RANKS-1:0] wr_en;
  wire [`ARS_NUM_RANKS-1:0][`ARS_CHAN_W-1:0] wr_chan;
  logic [`ARS_NUM_RANKS-1:0][`ARS_CHAN_W-1:0] ranks;
  logic [3:0] rd_idx;
  ars_chan_t rd_chan;

  modport store (input wr_en, input wr_chan, input rd_idx, output ranks, output rd_chan);
  modport ctrl (output wr_en, output wr_chan, output rd_idx, input ranks, input rd_chan);
endinterface

// file: verilog/ars_rank_store.sv
// sixteen rank channel fields with per-rank write and a registered read port
// assumes writes arrive as single-cycle enables from the bus side
module ars_rank_store (
  input wire logic clk,
  input wire logic rstn,
  ars_rank_if.store rif
);
  import ars_pkg::*;

  for (genvar r = 0; r < `ARS_NUM_RANKS; r++) begin : g_rank
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        rif.ranks[r] <= `ARS_CHAN_RESET;
      end else if (rif.wr_en[r]) begin
        rif.ranks[r] <= rif.wr_chan[r];
      end
    end
  end

  // the sequencer sees the selected rank one cycle after naming it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rif.rd_chan <= `ARS_CHAN_RESET;
    end else begin
      rif.rd_chan <= rif.ranks[rif.rd_idx];
    end
  end
endmodule

// file: sim/ars_monitor.sv
// concurrent checks of the regular sequence bank at its top-level ports
// assumes ars_pkg is compiled first; bound onto ars_top below
`include "ars_defines.svh"
module ars_monitor
  import ars_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`ARS_ADDR_W-1:0] PADDR,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CONV_REQ,
  input wire ars_chan_t CONV_CHANNEL,
  input wire logic CONV_DONE,
  input wire logic CONV_EOC,
  input wire logic SEQ_EOS,
  input wire logic SEQ_BUSY
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  wire logic unmapped = !(PADDR inside {`ARS_CTRL_OFF, `ARS_STAT_OFF, `ARS_SEQ1_OFF,
    `ARS_SEQ2_OFF, `ARS_SEQ3_OFF, `ARS_SEQ4_OFF, `ARS_DATA_OFF});
  wire logic bad_acc = unmapped || (PWRITE && PSTRB != 4'hF);
  wire logic rd_acc = PSEL && PENABLE && !PWRITE;
  a_ready_high: assert property (PREADY) else $error("pready low");
  a_err_code: assert property (PSEL && PENABLE |-> PSLVERR == bad_acc) else $error("pslverr wrong");
  a_resv_low: assert property (rd_acc && PADDR inside {`ARS_SEQ1_OFF, `ARS_SEQ2_OFF, `ARS_SEQ3_OFF}
    |-> (PRDATA & 32'hE0820820) == 32'h0) else $error("reserved bits set");
  a_resv_top: assert property (rd_acc && PADDR == `ARS_SEQ4_OFF |-> PRDATA[31:11] == 21'h0)
    else $error("upper bits set");
  a_start_req: assert property ($rose(SEQ_BUSY) |-> !CONV_REQ [*3] ##1 CONV_REQ)
    else $error("request late or early");
  a_req_hold: assert property (CONV_REQ && !CONV_DONE |=> CONV_REQ && $stable(CONV_CHANNEL))
    else $error("request not held");
  a_done_eoc: assert property (CONV_REQ && CONV_DONE |=> !CONV_REQ && CONV_EOC)
    else $error("done not answered");
  a_eoc_cause: assert property (CONV_EOC |-> $past(CONV_REQ) && $past(CONV_DONE))
    else $error("stray end of conversion");
  a_next_rank: assert property (CONV_EOC && !SEQ_EOS |-> ##2 CONV_REQ)
    else $error("next rank missing");
  a_eos_end: assert property (SEQ_EOS |-> CONV_EOC && !SEQ_BUSY) else $error("bad end of sequence");
  a_busy_fall: assert property ($fell(SEQ_BUSY) |-> SEQ_EOS) else $error("busy dropped early");
  a_idle_req: assert property (!SEQ_BUSY |-> !CONV_REQ) else $error("request while idle");
endmodule

bind ars_top ars_monitor u_mon (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CONV_REQ(CONV_REQ), .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE), .CONV_EOC(CONV_EOC),
  .SEQ_EOS(SEQ_EOS), .SEQ_BUSY(SEQ_BUSY));

// file: sim/ars_top_tb.sv
// self-checking bench of the regular sequence bank, apb master and converter stand-in
// assumes the design files and ars_monitor are compiled before it
`include "ars_defines.svh"
module ars_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ars_pkg::*;
  logic CORE_CLK, RSTN, PSEL, PENABLE, PWRITE, CONV_DONE, prev_req;
  logic [11:0] PADDR;
  logic [31:0] PWDATA;
  logic [3:0] PSTRB;
  wire logic [31:0] PRDATA;
  wire logic PREADY, PSLVERR, CONV_REQ, CONV_EOC, SEQ_EOS, SEQ_BUSY;
  wire ars_chan_t CONV_CHANNEL;
  ars_result_t CONV_RESULT, last_res;
  ars_chan_t r[16];
  ars_len_t len;
  logic [31:0] rd_q[$];
  logic err_q[$];
  ars_chan_t ch_q[$];
  int bad_count, cmp_count, cnt;
  ars_top u_dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CONV_REQ(CONV_REQ), .CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
    .CONV_EOC(CONV_EOC), .SEQ_EOS(SEQ_EOS), .SEQ_BUSY(SEQ_BUSY));
  initial begin
    CORE_CLK = 1'b0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // e is the error response expected for this transfer; only the watchdog ends the wait for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0);
    err_q.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
    end while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic x = 1'b0);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0, x);
  endtask
  // word k of the bank from len and the rank table
  function logic [31:0] pack(input int k);
    logic [31:0] w;
    int idx;
    w = (k == 0) ? {28'h0, len} : 32'h0;
    for (int i = 0; i < 5; i++) begin
      idx = 5 * k - 1 + i;
      if (idx >= 0 && idx < 16) w[6 * i +: 5] = r[idx];
    end
    return w;
  endfunction
  // converter stand-in: answers each request after 0 to 3 cycles
  always @(posedge CORE_CLK) begin
    if (CONV_REQ === 1'b1 && CONV_DONE !== 1'b1) begin
      if (cnt > 0) cnt--;
      else begin
        last_res = 16'($urandom);
        CONV_RESULT <= last_res;
        CONV_DONE <= 1'b1;
        cnt = $urandom_range(0, 3);
      end
    end else CONV_DONE <= 1'b0;
  end
  always @(posedge CORE_CLK) begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1 && PWRITE === 1'b0)
      chk(PRDATA, rd_q.size() ? rd_q.pop_front() : 'x);
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1)
      chk(32'(PSLVERR), err_q.size() ? 32'(err_q.pop_front()) : 'x);
    if (CONV_REQ === 1'b1 && prev_req !== 1'b1)
      chk(32'(CONV_CHANNEL), ch_q.size() ? 32'(ch_q.pop_front()) : 'x);
    prev_req = CONV_REQ;
  end
  initial begin
    #(8 * 20000);
    bad_count++;
    test_done;
  end
  initial begin
    {RSTN, PSEL, PENABLE, PWRITE, CONV_DONE, prev_req} = 6'h00;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    PSTRB = 4'hF;
    CONV_RESULT = 16'h0000;
    {cnt, bad_count, cmp_count} = 0;
    void'($urandom(64730));
    repeat (16) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    for (int k = 0; k < 4; k++) rd(12'(`ARS_SEQ1_OFF + 4 * k), 32'h0);
    rd(`ARS_DATA_OFF, 32'h0);
    rd(12'h010, 32'h0, 1'b1);
    for (int t = 0; t < 4; t++) begin
      len = (t == 0) ? 4'h0 : (t == 1) ? 4'hF : 4'($urandom);
      foreach (r[i]) r[i] = 5'($urandom_range(1, 18));
      for (int k = 0; k < 4; k++) apb(1'b1, 12'(`ARS_SEQ1_OFF + 4 * k), pack(k));
      PSTRB <= 4'h3;
      apb(1'b1, `ARS_SEQ2_OFF, ~pack(1), 1'b1);
      PSTRB <= 4'hF;
      apb(1'b1, `ARS_DATA_OFF, 32'h0000FFFF);
      for (int k = 0; k < 4; k++) rd(12'(`ARS_SEQ1_OFF + 4 * k), pack(k));
      for (int i = 0; i <= int'(len); i++) ch_q.push_back(r[i]);
      apb(1'b1, `ARS_CTRL_OFF, 32'h1);
      rd(`ARS_CTRL_OFF, 32'h1);
      while (SEQ_EOS !== 1'b1) begin
        @(posedge CORE_CLK);
      end
      rd(`ARS_DATA_OFF, {16'h0, last_res});
      rd(`ARS_CTRL_OFF, 32'h0);
      rd(`ARS_STAT_OFF, 32'h0);
      rd(`ARS_SEQ1_OFF, pack(0));
    end
    chk(32'(ch_q.size()), 32'h0);
    test_done;
  end
endmodule
